// file: common/flash_self_program_pkg.sv
package flash_self_program_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] CTRL_STATUS_ADDR = 32'h0000_0000;
  localparam logic [31:0] POINTER_ADDR     = 32'h0000_0004;
  localparam logic [31:0] WORD_DATA_ADDR   = 32'h0000_0008;
  localparam logic [31:0] READ_DATA_ADDR   = 32'h0000_000C;
  localparam logic [31:0] COMMAND_ADDR     = 32'h0000_0010;
  localparam logic [31:0] STATUS_ADDR      = 32'h0000_0014;
  localparam logic [31:0] FUSE_ADDR        = 32'h0000_0018;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int ENABLE_BIT     = 0;
  localparam int ERASE_BIT      = 1;
  localparam int WRITE_BIT      = 2;
  localparam int READBACK_BIT   = 3;
  localparam int CLEAR_BUF_BIT  = 4;
  localparam int CMD_STORE_BIT  = 0;
  localparam int CMD_LOAD_BIT   = 1;
  localparam int CMD_EEPROM_BIT = 2;

  // accepted low-five-bit patterns
  localparam logic [4:0] CODE_CLEAR    = 5'h11;
  localparam logic [4:0] CODE_READBACK = 5'h09;
  localparam logic [4:0] CODE_WRITE    = 5'h05;
  localparam logic [4:0] CODE_ERASE    = 5'h03;
  localparam logic [4:0] CODE_LOAD     = 5'h01;

  // readback pointer values
  localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
  localparam logic [15:0] PTR_LOCK      = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

  // ****************************************
  // timing
  // ****************************************
  localparam int LOAD_WINDOW  = 3;
  localparam int STORE_WINDOW = 4;
  localparam int CLK_HZ       = 50_000_000;
  localparam int PROG_MIN_US  = 3700;
  localparam int PROG_MAX_US  = 4500;
  localparam int PROG_MIN_CYC = (PROG_MIN_US * (CLK_HZ / 1_000_000));
  localparam int PROG_MAX_CYC = (PROG_MAX_US * (CLK_HZ / 1_000_000));

  // ****************************************
  // geometry
  // ****************************************
  localparam int PAGE_WORDS = 32;
  localparam int WORD_BITS  = $clog2(PAGE_WORDS);
  localparam int FLASH_BYTES = 8192;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_BUSY  = 2'b10
  } seq_state_t;

endpackage

// file: rtl/flash_self_program_control.sv
`timescale 1ns/10ps
`default_nettype none
module flash_self_program_control
  import flash_self_program_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_MAX_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // fuse and lock storage, 0 means programmed
  input  wire logic [7:0]  fuseLow,
  input  wire logic [7:0]  fuseHigh,
  input  wire logic [7:0]  fuseExt,
  input  wire logic [7:0]  lockBits,
  // flash side
  output logic             pageErase,
  output logic             pageWrite,
  output logic [15:0]      flashPage,
  output logic             cpuHalt
);

  // ****************************************
  // bus slave
  // ****************************************
  logic        dataPhase;
  logic        dataWrite;
  logic [31:0] dataAddr;
  wire         addrTaken = hsel && hready && htrans[1];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr  <= 32'h0000_0000;
    end else if (hready) begin
      dataPhase <= addrTaken;
      dataWrite <= hwrite;
      dataAddr  <= haddr;
    end
  end

  // halting the core means stretching any access that asks for a command
  wire busy;
  wire cmdSel     = dataAddr == COMMAND_ADDR;
  wire stallAcc   = dataPhase && busy && cmdSel;
  assign hreadyout = !stallAcc;
  assign hresp     = 1'b0;

  wire wrStrobe   = dataPhase && dataWrite && !stallAcc;
  wire wrCtrl     = wrStrobe && dataAddr == CTRL_STATUS_ADDR;
  wire wrPtr      = wrStrobe && dataAddr == POINTER_ADDR;
  wire wrData     = wrStrobe && dataAddr == WORD_DATA_ADDR;
  wire wrCmd      = wrStrobe && cmdSel;
  wire storeIns   = wrCmd && hwdata[CMD_STORE_BIT];
  wire loadIns    = wrCmd && hwdata[CMD_LOAD_BIT];

  // ****************************************
  // pointer and data registers
  // ****************************************
  logic [15:0] zPointer;
  logic [15:0] wordData;
  logic        eepromWritePending;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      zPointer           <= 16'h0000;
      wordData           <= 16'h0000;
      eepromWritePending <= 1'b0;
    end else begin
      if (wrPtr) zPointer <= hwdata[15:0];
      if (wrData) wordData <= hwdata[15:0];
      if (wrStrobe && dataAddr == STATUS_ADDR) eepromWritePending <= hwdata[CMD_EEPROM_BIT];
    end
  end

  wire [WORD_BITS-1:0] wordIndex = zPointer[WORD_BITS:1];
  wire [15:0]          pageIndex = {1'b0, zPointer[15:1]} >> WORD_BITS;

  // ****************************************
  // command arming
  // ****************************************
  seq_state_t  state;
  seq_state_t  next_state;
  logic [4:0]  ctrlBits;
  logic [2:0]  armCount;
  logic [31:0] progCount;

  wire [4:0] wrCode   = hwdata[4:0];
  wire codeOk = wrCode == CODE_CLEAR || wrCode == CODE_READBACK || wrCode == CODE_WRITE
             || wrCode == CODE_ERASE || wrCode == CODE_LOAD;
  wire acceptCtrl = wrCtrl && codeOk && !eepromWritePending && state != ST_BUSY;

  wire armedRead  = ctrlBits[READBACK_BIT] && ctrlBits[ENABLE_BIT];
  wire armedErase = ctrlBits[ERASE_BIT] && ctrlBits[ENABLE_BIT];
  wire armedWrite = ctrlBits[WRITE_BIT] && ctrlBits[ENABLE_BIT];
  wire armedLoad  = ctrlBits == CODE_LOAD;
  wire inArm      = state == ST_ARMED;
  wire loadOpen   = inArm && armCount < 3'(LOAD_WINDOW);
  wire storeOpen  = inArm && armCount < 3'(STORE_WINDOW);
  wire readHit    = loadIns && armedRead && loadOpen;
  wire opStart    = storeIns && storeOpen && (armedErase || armedWrite);
  wire wordStore  = storeIns && storeOpen && armedLoad;
  wire progDone   = state == ST_BUSY && progCount == 32'(PROG_CYCLES - 1);
  assign busy     = state == ST_BUSY;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (acceptCtrl) next_state = ST_ARMED;
      end
      ST_ARMED: begin
        // a fresh control write restarts the window instead of closing it
        if (opStart) next_state = ST_BUSY;
        else if (acceptCtrl) next_state = ST_ARMED;
        else if (readHit || wordStore || armCount == 3'(STORE_WINDOW - 1)) next_state = ST_IDLE;
        else if (armedRead && armCount == 3'(LOAD_WINDOW - 1)) next_state = ST_IDLE;
      end
      ST_BUSY: begin
        if (progDone) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // reset aborts a running operation; busyKeep only lets progCount count one more cycle
  logic busyKeep;
  always_ff @(posedge sys_clk) begin
    busyKeep <= busy && !progDone;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state    <= ST_IDLE;
      ctrlBits <= 5'h00;
      armCount <= 3'h0;
    end else begin
      state <= next_state;
      if (acceptCtrl) begin
        ctrlBits <= wrCode;
        armCount <= 3'h0;
      end else if (inArm) begin
        armCount <= armCount + 3'h1;
      end
      if (!acceptCtrl && next_state == ST_IDLE && state != ST_IDLE) ctrlBits <= 5'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (opStart) progCount <= 32'h0000_0000;
    else if (busy || busyKeep) progCount <= progCount + 32'h0000_0001;
  end

  // ****************************************
  // flash operations
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pageErase <= 1'b0;
      pageWrite <= 1'b0;
      flashPage <= 16'h0000;
    end else if (opStart) begin
      pageErase <= armedErase;
      pageWrite <= armedWrite;
      flashPage <= pageIndex;
    end else if (progDone) begin
      pageErase <= 1'b0;
      pageWrite <= 1'b0;
    end
  end
  assign cpuHalt = busy;

  // ****************************************
  // page buffer and program memory
  // ****************************************
  logic [15:0] pageBuffer [PAGE_WORDS];
  logic [7:0]  flashMem [FLASH_BYTES];
  wire clearBuf = acceptCtrl && wrCode == CODE_CLEAR;
  wire bufReset = clearBuf || (progDone && pageWrite);

  genvar gi;
  generate
    for (gi = 0; gi < PAGE_WORDS; gi++) begin : g_buf
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          pageBuffer[gi] <= 16'hFFFF;
        end else if (bufReset) begin
          pageBuffer[gi] <= 16'hFFFF;
        end else if (wordStore && wordIndex == WORD_BITS'(gi)) begin
          pageBuffer[gi] <= wordData;
        end
      end
    end
  endgenerate

  wire [12:0] pageBase = 13'(flashPage * PAGE_WORDS * 2);
  always_ff @(posedge sys_clk) begin
    if (progDone) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        flashMem[13'(pageBase + 13'(2 * i))]     <= pageErase ? 8'hFF : pageBuffer[i][7:0];
        flashMem[13'(pageBase + 13'(2 * i + 1))] <= pageErase ? 8'hFF : pageBuffer[i][15:8];
      end
    end
  end

  // ****************************************
  // load path
  // ****************************************
  // the whole pointer selects; values 0 to 3 pick a fuse or lock byte, others read FF
  wire [7:0] fuseByte =
      zPointer == PTR_LOCK      ? lockBits :
      zPointer == PTR_FUSE_EXT  ? fuseExt  :
      zPointer == PTR_FUSE_HIGH ? fuseHigh :
      zPointer == PTR_FUSE_LOW  ? fuseLow  : 8'hFF;
  wire [7:0] memByte = flashMem[zPointer[12:0]];

  logic [7:0] loadResult;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      loadResult <= 8'h00;
    end else if (readHit && !eepromWritePending) begin
      loadResult <= fuseByte;
    end else if (loadIns && !armedRead) begin
      loadResult <= memByte;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // bits seven to five read zero
  wire [7:0] ctrlView = {3'b000, ctrlBits};
  logic [31:0] next_hrdata;
  always_comb begin
    case (dataAddr)
      CTRL_STATUS_ADDR: next_hrdata = {24'h000000, ctrlView};
      POINTER_ADDR:     next_hrdata = {16'h0000, zPointer};
      WORD_DATA_ADDR:   next_hrdata = {16'h0000, wordData};
      READ_DATA_ADDR:   next_hrdata = {24'h000000, loadResult};
      STATUS_ADDR:      next_hrdata = {29'h00000000, eepromWritePending, busy, 1'b0};
      FUSE_ADDR:        next_hrdata = {flashPage, 16'h0000};
      default:          next_hrdata = 32'h0000_0000;
    endcase
  end
  assign hrdata = (dataPhase && !dataWrite) ? next_hrdata : 32'h0000_0000;

endmodule // flash_self_program_control
`default_nettype wire

// file: tb/flash_self_program_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// checker
// ****
module flash_self_program_checker
  import flash_self_program_pkg::*;
#(parameter int PROG_CYCLES = PROG_MAX_CYC) (
  // watched ports
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        pageErase,
  input wire logic        pageWrite,
  input wire logic [15:0] flashPage,
  input wire logic        cpuHalt
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire         busy = pageErase | pageWrite;
  logic [31:0] opLen;
  logic        rdCtrl;
  // length of the running op; a mid-op reset restarts it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opLen <= '0;
      rdCtrl <= 1'b0;
    end else begin
      opLen <= busy ? opLen + 32'h1 : '0;
      rdCtrl <= hsel && hready && htrans[1] && !hwrite && haddr == CTRL_STATUS_ADDR;
    end
  end
  sequence opStart; !busy ##1 busy; endsequence
  sequence opHeld; busy [*8]; endsequence
  a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
  a_halt_op: assert property (cpuHalt == busy) else $error("halt without op");
  a_op_held: assert property (opStart |-> opHeld) else $error("op too short");
  a_op_len: assert property ($fell(busy) |-> opLen >= PROG_CYCLES - 1 && opLen <= PROG_CYCLES + 1)
    else $error("op length off");
  a_page_held: assert property (busy && $past(busy) |-> $stable(flashPage)) else $error("page moved");
  a_stall_busy: assert property (!hreadyout |-> cpuHalt) else $error("stall while idle");
  a_stall_end: assert property (!hreadyout |-> ##[1:1000] hreadyout) else $error("stall hangs");
  a_rsvd_zero: assert property (rdCtrl |-> hrdata[7:5] == 3'b000) else $error("reserved bits set");
endmodule // flash_self_program_checker

bind flash_self_program_control flash_self_program_checker #(.PROG_CYCLES(PROG_CYCLES)) checker_i (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pageErase(pageErase),
  .pageWrite(pageWrite), .flashPage(flashPage), .cpuHalt(cpuHalt));
`default_nettype wire

// file: tb/flash_store_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// flash op record and fuse storage
// ****
module flash_store_model #(
  parameter logic [7:0] FUSE_LOW  = 8'h62,
  parameter logic [7:0] FUSE_HIGH = 8'hDF,
  parameter logic [7:0] FUSE_EXT  = 8'hFE,
  parameter logic [7:0] LOCK      = 8'hFC
) (
  // flash side
  input wire logic  sys_clk,
  input wire logic  pageErase,
  input wire logic  pageWrite,
  // fuse bytes, 0 means programmed
  output logic [7:0] fuseLow,
  output logic [7:0] fuseHigh,
  output logic [7:0] fuseExt,
  output logic [7:0] lockBits,
  // op record
  output int         opCount,
  output int         opLen
);
  int run = 0;
  int ops = 0;
  assign opCount = ops;
  assign fuseLow = FUSE_LOW;
  assign fuseHigh = FUSE_HIGH;
  assign fuseExt = FUSE_EXT;
  assign lockBits = LOCK;
  always @(posedge sys_clk) begin
    if (pageErase || pageWrite) begin
      run <= run + 1;
    end else if (run != 0) begin
      opLen <= run;
      ops <= ops + 1;
      run <= 0;
    end
  end
endmodule // flash_store_model
`default_nettype wire

// file: tb/flash_self_program_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// bench
// ****
module flash_self_program_control_tb_top
  import flash_self_program_pkg::*;
();
  localparam int PROG = 20;
  localparam logic [7:0] FL = 8'h62, FH = 8'hDF, FE = 8'hFE, LK = 8'hFC;
  logic        sys_clk = 1'b0, rst, hsel, hwrite, hreadyout, hresp, pageErase, pageWrite, cpuHalt;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] flashPage;
  logic [7:0]  fuseLow, fuseHigh, fuseExt, lockBits;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  int          opCount, opLen, error_cnt = 0, num_checks = 0;
  always #10 sys_clk = ~sys_clk;
  flash_self_program_control #(.PROG_CYCLES(PROG)) flash_self_program_control_i (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fuseLow(fuseLow),
    .fuseHigh(fuseHigh), .fuseExt(fuseExt), .lockBits(lockBits), .pageErase(pageErase),
    .pageWrite(pageWrite), .flashPage(flashPage), .cpuHalt(cpuHalt));
  flash_store_model #(.FUSE_LOW(FL), .FUSE_HIGH(FH), .FUSE_EXT(FE), .LOCK(LK)) flash_store_model_i (
    .sys_clk(sys_clk), .pageErase(pageErase), .pageWrite(pageWrite), .fuseLow(fuseLow), .fuseHigh(fuseHigh),
    .fuseExt(fuseExt), .lockBits(lockBits), .opCount(opCount), .opLen(opLen));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // sampled at the falling edge, so settled for the next rising one
  task automatic ready(output logic [31:0] rd);
    logic rdy;
    int   n;
    n = 0;
    do begin
      @(negedge sys_clk);
      rdy = hreadyout;
      rd = hrdata;
      n++;
      @(posedge sys_clk);
    end while (rdy !== 1'b1 && n < 2000);
    if (rdy !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    ready(rd);
    htrans <= 2'b00;
    hwdata <= d;
    ready(rd);
  endtask
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_cmp(input logic [31:0] a, exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    cmp(r, exp);
  endtask
  task automatic s_fuse_read();
    logic [7:0] exp [4];
    exp = '{FL, LK, FE, FH};
    for (int i = 0; i < 4; i++) begin
      wr(POINTER_ADDR, 32'(i));
      wr(CTRL_STATUS_ADDR, {27'h0, CODE_READBACK});
      wr(COMMAND_ADDR, 32'h2);
      rd_cmp(READ_DATA_ADDR, {24'h0, exp[i]});
      rd_cmp(CTRL_STATUS_ADDR, 32'h0);
    end
  endtask
  task automatic s_window();
    logic [4:0] codes [3];
    int         k;
    codes = '{CODE_LOAD, CODE_CLEAR, CODE_READBACK};
    wr(CTRL_STATUS_ADDR, 32'hE1);
    rd_cmp(CTRL_STATUS_ADDR, 32'h1);
    // read in the last open cycle, then in the first closed one
    foreach (codes[i]) begin
      k = (codes[i] == CODE_READBACK) ? LOAD_WINDOW - 2 : STORE_WINDOW - 2;
      wr(CTRL_STATUS_ADDR, {27'h0, codes[i]});
      repeat (k) @(posedge sys_clk);
      rd_cmp(CTRL_STATUS_ADDR, {27'h0, codes[i]});
      wr(CTRL_STATUS_ADDR, {27'h0, codes[i]});
      repeat (k + 1) @(posedge sys_clk);
      rd_cmp(CTRL_STATUS_ADDR, 32'h0);
    end
  endtask
  task automatic s_bad_codes();
    logic [4:0] codes [4];
    codes = '{5'h1F, 5'h10, 5'h07, 5'h08};
    foreach (codes[i]) begin
      wr(CTRL_STATUS_ADDR, {27'h0, codes[i]});
      rd_cmp(CTRL_STATUS_ADDR, 32'h0);
    end
  endtask
  task automatic s_eeprom();
    wr(STATUS_ADDR, 32'h4);
    wr(CTRL_STATUS_ADDR, {27'h0, CODE_READBACK});
    rd_cmp(CTRL_STATUS_ADDR, 32'h0);
    wr(CTRL_STATUS_ADDR, {27'h0, CODE_ERASE});
    wr(COMMAND_ADDR, 32'h1);
    repeat (2) @(negedge sys_clk);
    cmp({31'h0, cpuHalt}, 32'h0);
    @(posedge sys_clk);
    wr(STATUS_ADDR, 32'h0);
    rd_cmp(STATUS_ADDR, 32'h0);
    wr(CTRL_STATUS_ADDR, {27'h0, CODE_READBACK});
    rd_cmp(CTRL_STATUS_ADDR, {27'h0, CODE_READBACK});
  endtask
  task automatic s_program();
    logic [4:0]  code;
    logic [15:0] page;
    int          n;
    for (int k = 0; k < 2; k++) begin
      code = k ? CODE_WRITE : CODE_ERASE;
      page = 16'h5 + 16'(k);
      n = opCount;
      wr(POINTER_ADDR, {16'h0, page} << (WORD_BITS + 1));
      wr(CTRL_STATUS_ADDR, {27'h0, code});
      wr(COMMAND_ADDR, 32'h1);
      rd_cmp(CTRL_STATUS_ADDR, {27'h0, code});
      @(negedge sys_clk);
      cmp({16'h0, flashPage}, {16'h0, page});
      cmp({30'h0, pageWrite, pageErase}, k ? 32'h2 : 32'h1);
      @(posedge sys_clk);
      wr(COMMAND_ADDR, 32'h0);
      for (int j = 0; j < 50 && opCount == n; j++) @(posedge sys_clk);
      cmp(32'(opCount), 32'(n + 1));
      cmp({31'h0, opLen >= PROG - 1 && opLen <= PROG + 1}, 32'h1);
      rd_cmp(CTRL_STATUS_ADDR, 32'h0);
    end
  endtask
  task automatic s_fill_read();
    logic [15:0] base;
    logic [15:0] words [2];
    logic [7:0]  exp;
    base = 16'h3 << (WORD_BITS + 1);
    words = '{16'h3C5A, 16'hC3A5};
    for (int p = 0; p < 2; p++) begin
      for (int w = 0; w < 2; w++) begin
        // pointer bit zero set, must be ignored
        wr(POINTER_ADDR, {16'h0, base + 16'(2 * w + 1)});
        wr(WORD_DATA_ADDR, {16'h0, words[w]});
        wr(CTRL_STATUS_ADDR, {27'h0, CODE_LOAD});
        wr(COMMAND_ADDR, 32'h1);
      end
      // second pass throws the loaded words away
      if (p == 1) wr(CTRL_STATUS_ADDR, {27'h0, CODE_CLEAR});
      wr(POINTER_ADDR, {16'h0, base});
      wr(CTRL_STATUS_ADDR, {27'h0, CODE_WRITE});
      wr(COMMAND_ADDR, 32'h1);
      // stalls until the page write is over
      wr(COMMAND_ADDR, 32'h0);
      for (int b = 0; b < 4; b++) begin
        exp = p ? 8'hFF : (b[0] ? words[b / 2][15:8] : words[b / 2][7:0]);
        wr(POINTER_ADDR, {16'h0, base + 16'(b)});
        wr(COMMAND_ADDR, 32'h2);
        rd_cmp(READ_DATA_ADDR, {24'h0, exp});
      end
    end
  endtask
  initial begin
    rst <= 1'b1;
    hsel <= 1'b0;
    haddr <= '0;
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hsize <= 3'b010;
    hwdata <= '0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    s_fuse_read();
    s_window();
    s_bad_codes();
    s_eeprom();
    s_program();
    s_fill_read();
    tally_and_finish();
  end
endmodule // flash_self_program_control_tb_top
`default_nettype wire
